// file: timer_cc_pkg.sv
/*
 * Constants shared by the capture/compare channel pair logic: register offsets,
 * field positions, mode codes and the input filter lookup functions.
 * Assumes a 16-bit timer counter and a 32-bit APB register bus.
 */
package timer_cc_pkg;
   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam int unsigned ADDR_W = 8;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_PAIR_LO = 8'h18;
   localparam logic [7:0] OFS_PAIR_HI = 8'h1c;
   localparam logic [7:0] OFS_ENABLE = 8'h20;
   localparam logic [7:0] OFS_CV0 = 8'h34;
   localparam logic [7:0] OFS_CV1 = 8'h38;
   localparam logic [7:0] OFS_PROTECT = 8'h44;
   localparam logic [15:0] RESET_HALF = 16'h0000;
   // ---------------------------------------------------------------
   // Field layout of the pair register channel bytes and of the enable and protect registers
   // ---------------------------------------------------------------
   localparam int unsigned CH_STRIDE = 8;
   localparam int unsigned MS_LSB = 0;
   localparam int unsigned MS_W = 2;
   localparam int unsigned FEN_BIT = 2;
   localparam int unsigned SEN_BIT = 3;
   localparam int unsigned CTL_LSB = 4;
   localparam int unsigned CTL_MSB = 6;
   localparam int unsigned PSC_LSB = 2;
   localparam int unsigned FLT_LSB = 4;
   localparam int unsigned EN_STRIDE = 4;
   localparam int unsigned PROTECTION_LEVEL_LSB = 8;
   // ---------------------------------------------------------------
   // Codes
   // ---------------------------------------------------------------
   localparam logic [2:0] CMP_TIMING = 3'h0;
   localparam logic [2:0] CMP_SET = 3'h1;
   localparam logic [2:0] CMP_CLEAR = 3'h2;
   localparam logic [2:0] CMP_TOGGLE = 3'h3;
   localparam logic [2:0] CMP_FORCE_LOW = 3'h4;
   localparam logic [2:0] CMP_FORCE_HIGH = 3'h5;
   localparam logic [2:0] CMP_PWM0 = 3'h6;
   localparam logic [2:0] CMP_PWM1 = 3'h7;
   localparam logic [1:0] MS_OUTPUT = 2'h0;
   localparam logic [1:0] MS_OWN = 2'h1;
   localparam logic [1:0] MS_NEIGHBOUR = 2'h2;
   localparam logic [1:0] MS_TRIGGER = 2'h3;
   localparam logic [1:0] PROTECTION_LEVEL_LOCKED = 2'h3;
   localparam logic [3:0] FLT_BYPASS = 4'h0;

   // Number of equal samples a filter code asks for.
   function automatic logic [3:0] filt_len(input logic [3:0] code);
      case (code)
         4'h1: filt_len = 4'h2;
         4'h2: filt_len = 4'h4;
         4'h4, 4'h6, 4'h8, 4'hb, 4'he: filt_len = 4'h6;
         4'ha, 4'hd: filt_len = 4'h5;
         4'h0: filt_len = 4'h1;
         default: filt_len = 4'h8;
      endcase
   endfunction

   // Dead-time ticks per sample; one means every kernel clock.
   function automatic logic [5:0] filt_div(input logic [3:0] code);
      case (code)
         4'h4, 4'h5: filt_div = 6'h02;
         4'h6, 4'h7: filt_div = 6'h04;
         4'h8, 4'h9: filt_div = 6'h08;
         4'ha, 4'hb, 4'hc: filt_div = 6'h10;
         4'hd, 4'he, 4'hf: filt_div = 6'h20;
         default: filt_div = 6'h01;
      endcase
   endfunction

   // Capture every 1, 2, 4 or 8 edges.
   function automatic logic [2:0] psc_last(input logic [1:0] code);
      case (code)
         2'h0: psc_last = 3'h0;
         2'h1: psc_last = 3'h1;
         2'h2: psc_last = 3'h3;
         default: psc_last = 3'h7;
      endcase
   endfunction
endpackage

// file: filt_if.sv
/*
 * Link between the channel pair control and one input filter.
 * Assumes both ends run on pclk.
 */
`timescale 1ns/100ps
interface filt_if;
   logic [3:0] code;
   logic dts_tick;
   logic level;
   modport ctrl (output code, output dts_tick, input level);
   modport filt (input code, input dts_tick, output level);
endinterface

// file: capture_input_filter.sv
/*
 * Digital filter for one channel input pin: three-stage synchroniser,
 * sample-rate divider and equal-sample counter.
 * Assumes dts_tick is a one-cycle pulse on pclk at the dead-time rate.
 */
`timescale 1ns/100ps
module capture_input_filter (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pin_in,
   filt_if.filt cfg
);
   typedef struct packed {
      logic [2:0] sync;
      logic last;
      logic [3:0] cnt;
      logic [5:0] div;
      logic level;
   } filt_state_t;

   filt_state_t q, d;
   logic agree;
   logic tick;

   assign agree = (q.sync[2] == q.sync[1]);
   assign cfg.level = q.level;

   always_comb begin
      d = q;
      d.sync = {q.sync[1:0], pin_in};
      tick = 1'b0;
      if (timer_cc_pkg::filt_div(cfg.code) == 6'h01) begin
         tick = 1'b1;
      end else if (cfg.dts_tick) begin
         if (q.div >= timer_cc_pkg::filt_div(cfg.code) - 6'h01) begin
            d.div = 6'h00;
            tick = 1'b1;
         end else begin
            d.div = q.div + 6'h01;
         end
      end
      if (cfg.code == timer_cc_pkg::FLT_BYPASS) begin
         if (agree) begin
            d.level = q.sync[2];
         end
         d.cnt = 4'h0;
      end else if (tick && agree) begin
         if (q.sync[2] != q.last) begin
            d.last = q.sync[2];
            d.cnt = 4'h1;
         end else begin
            if (q.cnt < timer_cc_pkg::filt_len(cfg.code)) begin
               d.cnt = q.cnt + 4'h1;
            end
            if (d.cnt >= timer_cc_pkg::filt_len(cfg.code)) begin
               d.level = q.last;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   property p_bypass;
      @(posedge pclk) disable iff (!presetn)
      (cfg.code == timer_cc_pkg::FLT_BYPASS && agree) |=> (q.level == $past(q.sync[2]));
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass level not followed");

   property p_restart;
      @(posedge pclk) disable iff (!presetn)
      (cfg.code != timer_cc_pkg::FLT_BYPASS && tick && agree && q.sync[2] != q.last)
         |=> (q.cnt == 4'h1) && $stable(q.level);
   endproperty
   a_restart: assert property (p_restart) else $error("filter count not restarted");
endmodule

// file: timer_channel_capture_compare_cfg.sv
/*
 * Capture/compare configuration for timer channels 0 and 1: APB registers,
 * compare output prepare logic, input selection, filters and capture prescaler.
 * Assumes the counter, count direction, update event, trigger edge and
 * dead-time tick come from timer logic on pclk; channel pins are asynchronous.
 */
`timescale 1ns/100ps
module timer_channel_capture_compare_cfg #(
   parameter int unsigned CNT_W = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [CNT_W-1:0] counter_value,
   input wire logic count_down,
   input wire logic update_event,
   input wire logic trigger_edge,
   input wire logic internal_trigger_signal,
   input wire logic dead_time_tick,
   input wire logic [1:0] chan_pin,
   output logic [1:0] chan_output_prepare,
   output logic [1:0] capture_event,
   output logic [1:0] chan_selected_input
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [15:0] lo;
      logic [15:0] hi;
      logic [1:0] en;
      logic [1:0] protection_level;
      logic [1:0][CNT_W-1:0] cv;
      logic [1:0][CNT_W-1:0] cvs;
      logic [1:0] prep;
      logic [1:0] cmp_prev;
      logic [1:0][2:0] ctl_prev;
      logic [1:0] sel_prev;
      logic [1:0][2:0] psc_cnt;
      logic [1:0] cap;
      logic [31:0] rdata;
   } cc_state_t;

   cc_state_t q, d;
   logic [1:0] filt_level;
   logic [1:0] sel;
   logic wr;
   logic setup;
   logic hit;

   function automatic logic pwm_high(input logic [2:0] ctl, input logic down,
                                     input logic [CNT_W-1:0] cnt,
                                     input logic [CNT_W-1:0] cv);
      logic base;
      base = down ? !(cnt > cv) : (cnt < cv);
      pwm_high = (ctl == timer_cc_pkg::CMP_PWM0) ? base : !base;
   endfunction

   function automatic logic cmp_out(input logic down, input logic [CNT_W-1:0] cnt,
                                    input logic [CNT_W-1:0] cv);
      cmp_out = down ? (cnt > cv) : (cnt < cv);
   endfunction

   function automatic logic is_pwm(input logic [2:0] ctl);
      is_pwm = (ctl == timer_cc_pkg::CMP_PWM0) || (ctl == timer_cc_pkg::CMP_PWM1);
   endfunction

   // ---------------------------------------------------------------
   // Input filters
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : gen_filt
         filt_if link ();
         assign link.code = q.lo[g*timer_cc_pkg::CH_STRIDE+timer_cc_pkg::FLT_LSB +: 4];
         assign link.dts_tick = dead_time_tick;
         assign filt_level[g] = link.level;
         capture_input_filter u_filt (
            .pclk(pclk),
            .presetn(presetn),
            .pin_in(chan_pin[g]),
            .cfg(link)
         );
      end
   endgenerate

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   assign setup = psel && !penable;
   assign wr = psel && penable && pwrite;
   assign hit = (paddr == timer_cc_pkg::OFS_STATUS) || (paddr == timer_cc_pkg::OFS_PAIR_LO) ||
                (paddr == timer_cc_pkg::OFS_PAIR_HI) || (paddr == timer_cc_pkg::OFS_ENABLE) ||
                (paddr == timer_cc_pkg::OFS_CV0) || (paddr == timer_cc_pkg::OFS_CV1) ||
                (paddr == timer_cc_pkg::OFS_PROTECT);
   assign pready = psel && penable;
   assign pslverr = psel && penable && !hit;
   assign prdata = q.rdata;
   assign chan_output_prepare = q.prep;
   assign capture_event = q.cap;
   assign chan_selected_input = q.sel_prev;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      logic [1:0] ms;
      logic [2:0] ctl;
      logic locked;
      logic cmp;
      logic edge_seen;
      logic [CNT_W-1:0] wcv;
      int unsigned idx;
      ms = '0;
      ctl = '0;
      locked = 1'b0;
      cmp = 1'b0;
      edge_seen = 1'b0;
      wcv = pwdata[CNT_W-1:0];
      idx = 0;
      sel = '0;
      d = q;
      d.cap = '0;
      // Read data is captured in the setup phase so that it comes from a register.
      if (setup) begin
         case (paddr)
            timer_cc_pkg::OFS_STATUS: d.rdata = {26'h0000000, filt_level, q.sel_prev, q.prep};
            timer_cc_pkg::OFS_PAIR_LO: d.rdata = {16'h0000, q.lo};
            timer_cc_pkg::OFS_PAIR_HI: d.rdata = {16'h0000, q.hi};
            timer_cc_pkg::OFS_ENABLE: d.rdata = {27'h0000000, q.en[1], 3'h0, q.en[0]};
            timer_cc_pkg::OFS_CV0: d.rdata = {{(32-CNT_W){1'b0}}, q.cvs[0]};
            timer_cc_pkg::OFS_CV1: d.rdata = {{(32-CNT_W){1'b0}}, q.cvs[1]};
            timer_cc_pkg::OFS_PROTECT: d.rdata = {22'h000000, q.protection_level, 8'h00};
            default: d.rdata = 32'h00000000;
         endcase
      end
      if (wr && paddr == timer_cc_pkg::OFS_PAIR_HI) begin
         d.hi = pwdata[15:0];
      end
      if (wr && paddr == timer_cc_pkg::OFS_ENABLE) begin
         d.en = {pwdata[timer_cc_pkg::EN_STRIDE], pwdata[0]};
      end
      if (wr && paddr == timer_cc_pkg::OFS_PROTECT) begin
         d.protection_level = pwdata[timer_cc_pkg::PROTECTION_LEVEL_LSB +: 2];
      end
      for (int c = 0; c < 2; c++) begin
         ms = q.lo[c*timer_cc_pkg::CH_STRIDE+timer_cc_pkg::MS_LSB +: 2];
         ctl = q.lo[c*timer_cc_pkg::CH_STRIDE+timer_cc_pkg::CTL_LSB +: 3];
         locked = (q.protection_level == timer_cc_pkg::PROTECTION_LEVEL_LOCKED) && (ms == timer_cc_pkg::MS_OUTPUT);
         // Pair register write, bit by bit: mode bits guarded by enable, bits 3 to 6 by the lock, bits 2 and 7 unguarded.
         if (wr && paddr == timer_cc_pkg::OFS_PAIR_LO) begin
            for (int b = 0; b < timer_cc_pkg::CH_STRIDE; b++) begin
               idx = c * timer_cc_pkg::CH_STRIDE + b;
               if (b < timer_cc_pkg::MS_W) begin
                  if (!q.en[c]) begin
                     d.lo[idx] = pwdata[idx];
                  end
               end else if (b >= timer_cc_pkg::SEN_BIT && b <= timer_cc_pkg::CTL_MSB) begin
                  if (!locked) begin
                     d.lo[idx] = pwdata[idx];
                  end
               end else begin
                  d.lo[idx] = pwdata[idx];
               end
            end
         end
         // Compare value: preload through the shadow or write straight through.
         if (q.lo[c*timer_cc_pkg::CH_STRIDE+timer_cc_pkg::SEN_BIT]) begin
            if (update_event) begin
               d.cv[c] = q.cvs[c];
            end
         end
         if (wr && paddr == (c == 0 ? timer_cc_pkg::OFS_CV0 : timer_cc_pkg::OFS_CV1)) begin
            d.cvs[c] = wcv;
            if (!q.lo[c*timer_cc_pkg::CH_STRIDE+timer_cc_pkg::SEN_BIT]) begin
               d.cv[c] = wcv;
            end
         end
         // Output prepare.
         cmp = cmp_out(count_down, counter_value, q.cv[c]);
         if (ms == timer_cc_pkg::MS_OUTPUT) begin
            case (ctl)
               timer_cc_pkg::CMP_TIMING: d.prep[c] = q.prep[c];
               timer_cc_pkg::CMP_SET: d.prep[c] = q.prep[c] | (counter_value == q.cv[c]);
               timer_cc_pkg::CMP_CLEAR: d.prep[c] = q.prep[c] & (counter_value != q.cv[c]);
               timer_cc_pkg::CMP_TOGGLE: d.prep[c] = q.prep[c] ^ (counter_value == q.cv[c]);
               timer_cc_pkg::CMP_FORCE_LOW: d.prep[c] = 1'b0;
               timer_cc_pkg::CMP_FORCE_HIGH: d.prep[c] = 1'b1;
               default: begin
                  if (q.ctl_prev[c] == timer_cc_pkg::CMP_TIMING || cmp != q.cmp_prev[c]) begin
                     d.prep[c] = pwm_high(ctl, count_down, counter_value, q.cv[c]);
                  end
               end
            endcase
            if (q.lo[c*timer_cc_pkg::CH_STRIDE+timer_cc_pkg::FEN_BIT] && is_pwm(ctl) &&
                trigger_edge) begin
               // Level reached after a match: low in PWM mode 0, high in PWM mode 1.
               d.prep[c] = (ctl == timer_cc_pkg::CMP_PWM1);
            end
         end
         d.cmp_prev[c] = cmp;
         d.ctl_prev[c] = ctl;
         // Input selection; the selected input is held low in output mode.
         case (ms)
            timer_cc_pkg::MS_OWN: sel[c] = filt_level[c];
            timer_cc_pkg::MS_NEIGHBOUR: sel[c] = filt_level[1-c];
            timer_cc_pkg::MS_TRIGGER: sel[c] = internal_trigger_signal;
            default: sel[c] = 1'b0;
         endcase
         d.sel_prev[c] = sel[c];
         edge_seen = sel[c] && !q.sel_prev[c] && (ms != timer_cc_pkg::MS_OUTPUT);
         // Capture prescaler counts rising edges of the selected input.
         if (!q.en[c]) begin
            d.psc_cnt[c] = 3'h0;
         end else if (edge_seen) begin
            if (q.psc_cnt[c] >= timer_cc_pkg::psc_last(
                   q.lo[c*timer_cc_pkg::CH_STRIDE+timer_cc_pkg::PSC_LSB +: 2])) begin
               d.psc_cnt[c] = 3'h0;
               d.cap[c] = 1'b1;
            end else begin
               d.psc_cnt[c] = q.psc_cnt[c] + 3'h1;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // ---------------------------------------------------------------
   // Checks on channel 0
   // ---------------------------------------------------------------
   logic [1:0] ms0;
   logic [2:0] ctl0;
   logic fen0;
   logic sen0;
   logic cmp0;
   assign ms0 = q.lo[1:0];
   assign ctl0 = q.lo[6:4];
   assign fen0 = q.lo[timer_cc_pkg::FEN_BIT];
   assign sen0 = q.lo[timer_cc_pkg::SEN_BIT];
   assign cmp0 = cmp_out(count_down, counter_value, q.cv[0]);

   property p_pwm1;
      @(posedge pclk) disable iff (!presetn)
      (ms0 == timer_cc_pkg::MS_OUTPUT && ctl0 == timer_cc_pkg::CMP_PWM1 && !(fen0 && trigger_edge)
       && cmp0 != q.cmp_prev[0]) |=> (q.prep[0] == $past(count_down ~^ cmp0));
   endproperty
   a_pwm1: assert property (p_pwm1) else $error("pwm mode 1 level wrong");

   property p_pwm0;
      @(posedge pclk) disable iff (!presetn)
      (ms0 == timer_cc_pkg::MS_OUTPUT && ctl0 == timer_cc_pkg::CMP_PWM0 && !(fen0 && trigger_edge)
       && q.ctl_prev[0] == timer_cc_pkg::CMP_TIMING) |=> (q.prep[0] == $past(count_down ^ cmp0));
   endproperty
   a_pwm0: assert property (p_pwm0) else $error("pwm mode 0 level wrong");

   property p_pwm_hold;
      @(posedge pclk) disable iff (!presetn)
      (is_pwm(ctl0) && q.ctl_prev[0] != timer_cc_pkg::CMP_TIMING && cmp0 == q.cmp_prev[0]
       && !(fen0 && trigger_edge)) |=> $stable(q.prep[0]);
   endproperty
   a_pwm_hold: assert property (p_pwm_hold) else $error("pwm level moved without cause");

   property p_timing;
      @(posedge pclk) disable iff (!presetn)
      (ctl0 == timer_cc_pkg::CMP_TIMING) |=> $stable(q.prep[0]);
   endproperty
   a_timing: assert property (p_timing) else $error("timing mode changed output");

   property p_protect;
      @(posedge pclk) disable iff (!presetn)
      (wr && paddr == timer_cc_pkg::OFS_PAIR_LO && q.protection_level == timer_cc_pkg::PROTECTION_LEVEL_LOCKED &&
       ms0 == timer_cc_pkg::MS_OUTPUT) |=> $stable(q.lo[6:3]);
   endproperty
   a_protect: assert property (p_protect) else $error("locked field was written");

   property p_shadow;
      @(posedge pclk) disable iff (!presetn)
      (sen0 && update_event) |=> (q.cv[0] == $past(q.cvs[0]));
   endproperty
   a_shadow: assert property (p_shadow) else $error("shadow not transferred");

   property p_fast;
      @(posedge pclk) disable iff (!presetn)
      (ms0 == timer_cc_pkg::MS_OUTPUT && fen0 && ctl0 == timer_cc_pkg::CMP_PWM1 && trigger_edge)
         |=> q.prep[0];
   endproperty
   a_fast: assert property (p_fast) else $error("fast trigger not applied");

   property p_ms_lock;
      @(posedge pclk) disable iff (!presetn)
      (wr && paddr == timer_cc_pkg::OFS_PAIR_LO && q.en[0]) |=> $stable(ms0);
   endproperty
   a_ms_lock: assert property (p_ms_lock) else $error("mode written while enabled");

   property p_psc_reset;
      @(posedge pclk) disable iff (!presetn)
      (!q.en[0]) |=> (q.psc_cnt[0] == 3'h0) && !q.cap[0];
   endproperty
   a_psc_reset: assert property (p_psc_reset) else $error("prescaler not cleared");

   property p_capture;
      @(posedge pclk) disable iff (!presetn)
      (q.en[0] && ms0 != timer_cc_pkg::MS_OUTPUT && q.lo[3:2] == 2'h0 && sel[0] && !q.sel_prev[0])
         |=> capture_event[0];
   endproperty
   a_capture: assert property (p_capture) else $error("capture missed");

   c_pwm_entry: cover property (@(posedge pclk) disable iff (!presetn)
      (ctl0 == timer_cc_pkg::CMP_PWM1 && q.ctl_prev[0] == timer_cc_pkg::CMP_TIMING));
   c_capture_by4: cover property (@(posedge pclk) disable iff (!presetn)
      (capture_event[0] && q.lo[3:2] == 2'h2));
   c_shadow_load: cover property (@(posedge pclk) disable iff (!presetn)
      (sen0 && update_event && q.cv[0] != q.cvs[0]));
endmodule

// file: chan_pin_model.sv
/* Model of the two channel input pins that face the block.
   Assumes every change is launched just after a rising edge of pclk. */
`timescale 1ns/100ps
module chan_pin_model (
   input wire logic pclk,
   output logic [1:0] pins
);
   initial pins = 2'h0;
   task automatic drive(input int ch, input logic v);
      @(posedge pclk);
      pins[ch] <= v;
   endtask
   // High for n cycles; back-to-back calls leave one low cycle between pulses.
   task automatic pulse(input int ch, input int n);
      drive(ch, 1'b1);
      repeat (n - 1) @(posedge pclk);
      drive(ch, 1'b0);
   endtask
endmodule

// file: timer_channel_capture_compare_cfg_test.sv
/* Self-checking bench for the channel pair configuration block.
   Assumes the pin model drives the channel inputs and APB has no wait states. */
`timescale 1ns/100ps
module timer_channel_capture_compare_cfg_test;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic count_down = 1'b0, update_event = 1'b0, trigger_edge = 1'b0;
   logic internal_trigger_signal = 1'b0, dt = 1'b0, pready, pslverr, err;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [15:0] counter_value = 16'h0;
   logic [1:0] pins, prep, cap, sel;
   int failures = 0, tests_run = 0, caps = 0, c0, caps1 = 0, c1;
   always #5 pclk = ~pclk;
   // Dead-time tick every other cycle keeps the slow filter codes short.
   always @(posedge pclk) dt <= ~dt;
   always @(posedge pclk) caps <= caps + int'(cap[0]);
   always @(posedge pclk) caps1 <= caps1 + int'(cap[1]);
   chan_pin_model pm (.pclk, .pins);
   timer_channel_capture_compare_cfg uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .counter_value, .count_down, .update_event,
      .trigger_edge, .internal_trigger_signal, .dead_time_tick(dt), .chan_pin(pins),
      .chan_output_prepare(prep), .capture_event(cap), .chan_selected_input(sel));
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic setc(input logic [15:0] v, input logic d);
      @(posedge pclk);
      counter_value <= v;
      count_down <= d;
      tick(2);
   endtask
   task automatic t_regs;
      apb(1'b0, 8'h1c, 32'h0);
      chk("hi reset", 32'h0, rd);
      apb(1'b1, 8'h1c, 32'hffff_ffff);
      apb(1'b0, 8'h1c, 32'h0);
      chk("hi word", 32'h0000_ffff, rd);
      apb(1'b0, 8'h60, 32'h0);
      chk("unmapped", 32'h1, 32'(err));
      apb(1'b1, 8'h18, 32'h5000);
      tick(1);
      chk("ch1 force high", 32'h1, 32'(prep[1]));
      $display("test regs done");
   endtask
   task automatic t_pwm;
      logic [15:0] c;
      apb(1'b1, 8'h34, 32'd10);
      for (int i = 0; i < 8; i++) begin
         c = (i[0] ^ i[1]) ? 16'd15 : 16'd5;
         if (i == 4) apb(1'b1, 8'h18, 32'h0);
         apb(1'b1, 8'h18, (i < 4) ? 32'h78 : 32'h68);
         setc(c, i[1]);
         chk("pwm", 32'((c == 16'd15) ^ (i > 3)), 32'(prep[0]));
      end
      apb(1'b1, 8'h18, 32'h0);
      setc(16'd15, 1'b0);
      chk("timing hold", 32'h1, 32'(prep[0]));
      $display("test pwm done");
   endtask
   task automatic t_shadow_fast;
      apb(1'b1, 8'h18, 32'h78);
      apb(1'b1, 8'h34, 32'd20);
      tick(2);
      chk("shadow held", 32'h1, 32'(prep[0]));
      @(posedge pclk);
      update_event <= 1'b1;
      @(posedge pclk);
      update_event <= 1'b0;
      tick(2);
      chk("shadow load", 32'h0, 32'(prep[0]));
      apb(1'b1, 8'h18, 32'h7c);
      @(posedge pclk);
      trigger_edge <= 1'b1;
      @(posedge pclk);
      trigger_edge <= 1'b0;
      #1;
      chk("fast match", 32'h1, 32'(prep[0]));
      $display("test shadow fast done");
   endtask
   task automatic t_mode;
      apb(1'b1, 8'h18, 32'h0);
      apb(1'b1, 8'h20, 32'h1);
      apb(1'b1, 8'h18, 32'h1);
      apb(1'b0, 8'h18, 32'h0);
      chk("mode locked", 32'h0, rd);
      apb(1'b1, 8'h20, 32'h0);
      internal_trigger_signal <= 1'b1;
      apb(1'b1, 8'h18, 32'h3);
      tick(3);
      chk("trigger sel", 32'h1, 32'(sel[0]));
      apb(1'b1, 8'h18, 32'h0102);
      apb(1'b1, 8'h20, 32'h11);
      c0 = caps;
      c1 = caps1;
      pm.drive(1, 1'b1);
      tick(8);
      chk("neighbour sel", 32'h3, 32'(sel));
      chk("capture ch0", 32'h1, caps - c0);
      chk("capture ch1", 32'h1, caps1 - c1);
      apb(1'b1, 8'h20, 32'h0);
      pm.drive(1, 1'b0);
      internal_trigger_signal <= 1'b0;
      $display("test mode done");
   endtask
   task automatic t_filter;
      apb(1'b1, 8'h18, 32'h35);
      apb(1'b1, 8'h20, 32'h1);
      // The gap must hold long enough for the synchroniser to agree on it.
      repeat (2) begin
         pm.pulse(0, 6);
         tick(2);
      end
      tick(14);
      chk("glitch", 32'h0, 32'(sel[0]));
      c0 = caps;
      repeat (4) begin
         pm.pulse(0, 16);
         tick(16);
      end
      chk("prescale 2", 32'd2, caps - c0);
      c0 = caps;
      pm.pulse(0, 16);
      tick(16);
      apb(1'b1, 8'h20, 32'h0);
      apb(1'b1, 8'h20, 32'h1);
      pm.pulse(0, 16);
      tick(16);
      chk("prescale clear", 32'd0, caps - c0);
      apb(1'b1, 8'h18, 32'h45);
      pm.pulse(0, 16);
      tick(8);
      chk("slow reject", 32'h0, 32'(sel[0]));
      pm.drive(0, 1'b1);
      tick(40);
      chk("slow accept", 32'h1, 32'(sel[0]));
      pm.drive(0, 1'b0);
      $display("test filter done");
   endtask
   task automatic t_protection_level;
      apb(1'b1, 8'h20, 32'h0);
      apb(1'b1, 8'h18, 32'h0);
      apb(1'b1, 8'h44, 32'h300);
      apb(1'b1, 8'h18, 32'h7c);
      apb(1'b0, 8'h18, 32'h0);
      chk("protected", 32'h04, rd);
      $display("test protection_level done");
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_pwm;
      t_shadow_fast;
      t_mode;
      t_filter;
      t_protection_level;
      results;
   end
   // The whole run needs about five hundred cycles.
   initial begin
      #200000;
      failures++;
      results;
   end
endmodule
